/* File: design/msc_pkg.sv */
// constants, types and helpers for the modem serial command block
// assumes a single 200 MHz clock and 8-bit settings on a 32-bit bus
// Behaviour
// RULE1: grouping code splits 24 frequencies
// RULE2: low five bits select group number
// RULE3: multidrop responses spaced by packet interval
// RULE4: software keeps packet interval above gap
// RULE5: software leaves reserved registers at defaults
// RULE6: marker character starts a command
// RULE7: marker counts only after idle guard
// RULE8: retransmissions limited to programmed count
// RULE9: error response past limit, broadcast +1
// RULE10: weak beacon below threshold starts scanning
// RULE11: programmed gap between output characters
// RULE12: output drains buffer, no other spacing
// RULE13: guard time counted in tenth seconds
// RULE14: guard zero always, 255 never recognised
// RULE15: command timeout returns to data wait
// RULE16: timeout in tenths, zero disables
// RULE17: new settings apply only after reset
// RULE18: early marker forwarded as ordinary data
// RULE19: idle timers restart on each character
package msc_pkg;
   // timing
   localparam int CLK_PERIOD_NS = 5;
   localparam int MS_NS = 1_000_000;
   localparam int TENTH_NS = 100_000_000;
   localparam int MS_CYCLES = MS_NS / CLK_PERIOD_NS;
   localparam int TENTH_CYCLES = TENTH_NS / CLK_PERIOD_NS;
   // bus
   localparam int ADDR_W = 12;
   localparam logic [1:0] RESP_OKAY = 2'h0;
   localparam logic [1:0] RESP_SLVERR = 2'h2;
   // register byte addresses
   localparam logic [11:0] FREQ_ADDR = 12'h018;
   localparam logic [11:0] PKT_ADDR = 12'h01c;
   localparam logic [11:0] RSVA_ADDR = 12'h020;
   localparam logic [11:0] RSVB_ADDR = 12'h024;
   localparam logic [11:0] MARK_ADDR = 12'h028;
   localparam logic [11:0] RETRY_ADDR = 12'h02c;
   localparam logic [11:0] BEACON_ADDR = 12'h030;
   localparam logic [11:0] RSVC_ADDR = 12'h034;
   localparam logic [11:0] GAP_ADDR = 12'h038;
   localparam logic [11:0] GUARD_ADDR = 12'h03c;
   localparam logic [11:0] CTO_ADDR = 12'h040;
   localparam logic [11:0] RSVD_ADDR = 12'h044;
   localparam logic [11:0] CTRL_ADDR = 12'h080;
   localparam logic [11:0] STATUS_ADDR = 12'h084;
   localparam logic [11:0] MASK_ADDR = 12'h088;
   localparam logic [11:0] STATE_ADDR = 12'h08c;
   // values after reset
   localparam logic [7:0] FREQ_RST = 8'ha0;
   localparam logic [7:0] PKT_RST = 8'h05;
   localparam logic [7:0] RSVA_RST = 8'h11;
   localparam logic [7:0] RSVB_RST = 8'h13;
   localparam logic [7:0] MARK_RST = 8'h40;
   localparam logic [7:0] RETRY_RST = 8'h32;
   localparam logic [7:0] BEACON_RST = 8'hb4;
   localparam logic [7:0] RSVC_RST = 8'h1e;
   localparam logic [7:0] GAP_RST = 8'h00;
   localparam logic [7:0] GUARD_RST = 8'h00;
   localparam logic [7:0] CTO_RST = 8'h32;
   localparam logic [7:0] RSVD_RST = 8'h32;
   localparam logic [7:0] IDLE_RST = 8'hff;
   // fields and special codes
   localparam int GRP_MSB = 7;
   localparam int GRP_LSB = 5;
   localparam int NUM_MSB = 4;
   localparam int CTRL_APPLY_BIT = 0;
   localparam logic [7:0] GUARD_ANY = 8'h00;
   localparam logic [7:0] GUARD_NEVER = 8'hff;
   localparam logic [7:0] CTO_OFF = 8'h00;
   localparam logic [7:0] CNT_MAX = 8'hff;
   // interrupt status bits
   localparam int IRQ_W = 4;
   localparam int IRQ_CMD = 0;
   localparam int IRQ_TMO = 1;
   localparam int IRQ_ERR = 2;
   localparam int IRQ_SCAN = 3;

   // command interpreter modes, gray along data -> command
   typedef enum logic [1:0] {
      MSC_DATA_WAIT = 2'h0,
      MSC_CMD_WAIT = 2'h1
   } msc_mode_e;

   // settings bundle, pending or active
   typedef struct packed {
      logic [7:0] freq;
      logic [7:0] pkt;
      logic [7:0] marker;
      logic [7:0] retry;
      logic [7:0] beacon;
      logic [7:0] gap;
      logic [7:0] guard;
      logic [7:0] cto;
   } msc_cfg_s;

   localparam msc_cfg_s CFG_RST = '{freq: FREQ_RST, pkt: PKT_RST,
      marker: MARK_RST, retry: RETRY_RST, beacon: BEACON_RST,
      gap: GAP_RST, guard: GUARD_RST, cto: CTO_RST};

   // frequencies in each group for a grouping code
   function automatic logic [4:0] msc_per_group(input logic [2:0] m);
      case (m)
         3'h0: return 5'h18;
         3'h1: return 5'h0c;
         3'h2: return 5'h08;
         3'h3: return 5'h06;
         3'h4: return 5'h04;
         3'h5: return 5'h03;
         3'h6: return 5'h02;
         default: return 5'h01;
      endcase
   endfunction : msc_per_group

   // number of groups for a grouping code
   function automatic logic [4:0] msc_groups(input logic [2:0] m);
      return 5'(5'h18 / msc_per_group(m));
   endfunction : msc_groups
endpackage : msc_pkg

/* File: design/msc_tick.sv */
// free tick divider with a restart input
// assumes restart and ce are synchronous to aclk
`timescale 1ns/1ps
module msc_tick import msc_pkg::*; #(
   parameter int PERIOD = MS_CYCLES
) (
   // clock, reset, enable
   input wire logic aclk,
   input wire logic aresetn,
   input wire logic ce,
   // restart the period from zero
   input wire logic restart,
   // one-cycle pulse per full period
   output logic tick
);
   localparam int W = $clog2(PERIOD + 1);
   localparam logic [W-1:0] LAST = W'(PERIOD - 1);

   logic [W-1:0] cnt; // cycles into the period
   logic [W-1:0] next_cnt;
   logic next_tick;

   // restart aligns the period to the last event, so a full tick is
   // always a full period after it
   always_comb begin
      next_tick = !restart && (cnt == LAST);
      next_cnt = (restart || next_tick) ? '0 : cnt + 1'b1;
   end

   // register stage
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         cnt <= '0;
         tick <= 1'b0;
      end else if (ce) begin
         cnt <= next_cnt;
         tick <= next_tick;
      end
   end
endmodule : msc_tick

/* File: design/msc_core.sv */
// serial command settings, command detection and output pacing
// assumes characters arrive as one-cycle strobes at end of stop bit
`timescale 1ns/1ps
module msc_core import msc_pkg::*; #(
   parameter int MS_TICKS = MS_CYCLES,
   parameter int TENTH_TICKS = TENTH_CYCLES
) (
   // clock, reset, enable
   input wire logic aclk,
   input wire logic aresetn,
   input wire logic ce,
   // axi4-lite write
   input wire logic awvalid,
   output logic awready,
   input wire logic [ADDR_W-1:0] awaddr,
   input wire logic wvalid,
   output logic wready,
   input wire logic [31:0] wdata,
   input wire logic [3:0] wstrb,
   output logic bvalid,
   input wire logic bready,
   output logic [1:0] bresp,
   // axi4-lite read
   input wire logic arvalid,
   output logic arready,
   input wire logic [ADDR_W-1:0] araddr,
   output logic rvalid,
   input wire logic rready,
   output logic [31:0] rdata,
   output logic [1:0] rresp,
   // characters from the terminal
   input wire logic rx_valid,
   input wire logic [7:0] rx_data,
   // ordinary data and command characters
   output logic fwd_valid,
   output logic [7:0] fwd_data,
   output logic cmd_valid,
   output logic [7:0] cmd_data,
   input wire logic cmd_end,
   // buffered characters toward the terminal
   input wire logic out_valid,
   input wire logic [7:0] out_data,
   input wire logic out_first,
   output logic out_ready,
   input wire logic multidrop_en,
   // serial transmitter
   output logic term_valid,
   output logic [7:0] term_data,
   input wire logic term_ready,
   input wire logic term_done,
   // retransmission
   input wire logic tx_fail,
   input wire logic tx_ok,
   input wire logic tx_broadcast,
   output logic retry_req,
   output logic retry_error,
   // roaming
   input wire logic roam_en,
   input wire logic beacon_valid,
   input wire logic [7:0] beacon_level,
   output logic scan_start,
   // frequency plan
   output logic [4:0] freq_per_group,
   output logic [4:0] group_total,
   output logic [4:0] group_num,
   output logic group_legal,
   // interrupt
   output logic irq
);
   // bus side state
   logic aw_got, next_aw_got;
   logic [ADDR_W-1:0] aw_addr, next_aw_addr;
   logic w_got, next_w_got;
   logic [7:0] w_byte, next_w_byte; // low lane of write data
   logic w_lane, next_w_lane; // low byte strobe
   logic next_bvalid, next_rvalid;
   logic [1:0] next_bresp, next_rresp;
   logic [31:0] next_rdata;
   msc_cfg_s pend, next_pend; // what software last wrote
   msc_cfg_s act, next_act; // what the logic runs on
   logic apply, next_apply; // soft reset request
   logic [IRQ_W-1:0] mask, next_mask;
   logic [IRQ_W-1:0] clr; // write-one-to-clear bits
   logic wr_fire;
   // core state
   msc_mode_e mode, next_mode;
   logic [7:0] idle, next_idle; // tenths since last rx char
   logic [7:0] gap_cnt, next_gap_cnt; // ms since last output
   logic busy, next_busy; // char handed to transmitter
   logic [7:0] rcnt, next_rcnt; // retransmissions so far
   logic [IRQ_W-1:0] status, next_status;
   logic [IRQ_W-1:0] ev;
   logic next_fwd_valid, next_cmd_valid, next_term_valid;
   logic [7:0] next_fwd_data, next_cmd_data, next_term_data;
   logic next_retry_req, next_retry_error, next_scan;
   logic [4:0] next_per, next_total, next_num;
   logic next_legal;
   // helpers
   logic tenth_tick, ms_tick, guard_ok, tmo, gap_ok, hdr;
   logic [7:0] need;
   logic [8:0] limit;

   // register map membership for both answers
   function automatic logic mapped(input logic [ADDR_W-1:0] a);
      case (a)
         FREQ_ADDR, PKT_ADDR, RSVA_ADDR, RSVB_ADDR, MARK_ADDR,
         RETRY_ADDR, BEACON_ADDR, RSVC_ADDR, GAP_ADDR, GUARD_ADDR,
         CTO_ADDR, RSVD_ADDR, CTRL_ADDR, STATUS_ADDR, MASK_ADDR,
         STATE_ADDR: return 1'b1;
         default: return 1'b0;
      endcase
   endfunction : mapped

   // 0.1 s timebase, realigned on each rx character
   // RULE19 restart on character
   msc_tick #(.PERIOD(TENTH_TICKS)) u_tenth (
      .aclk(aclk),
      .aresetn(aresetn),
      .ce(ce),
      .restart(rx_valid),
      .tick(tenth_tick)
   );

   // 1 ms timebase, realigned at each stop bit
   msc_tick #(.PERIOD(MS_TICKS)) u_ms (
      .aclk(aclk),
      .aresetn(aresetn),
      .ce(ce),
      .restart(term_done),
      .tick(ms_tick)
   );

   // handshake readies
   assign awready = ce && !aw_got && !bvalid;
   assign wready = ce && !w_got && !bvalid;
   assign arready = ce && !rvalid;
   assign wr_fire = aw_got && w_got && !bvalid;

   // bus, settings and mask: next values
   always_comb begin
      next_aw_got = aw_got;
      next_aw_addr = aw_addr;
      next_w_got = w_got;
      next_w_byte = w_byte;
      next_w_lane = w_lane;
      next_bvalid = bvalid && !bready;
      next_bresp = bresp;
      next_rvalid = rvalid && !rready;
      next_rresp = rresp;
      next_rdata = rdata;
      next_pend = pend;
      next_mask = mask;
      next_apply = 1'b0;
      clr = '0;
      // address and data may come in either order
      if (awvalid && awready) begin
         next_aw_got = 1'b1;
         next_aw_addr = awaddr;
      end
      if (wvalid && wready) begin
         next_w_got = 1'b1;
         next_w_byte = wdata[7:0];
         next_w_lane = wstrb[0];
      end
      if (wr_fire) begin
         next_aw_got = 1'b0;
         next_w_got = 1'b0;
         next_bvalid = 1'b1;
         next_bresp = mapped(aw_addr) ? RESP_OKAY : RESP_SLVERR;
         // reserved words are read-only; a cleared lane writes nothing
         if (w_lane) begin
            case (aw_addr)
               FREQ_ADDR: next_pend.freq = w_byte;
               PKT_ADDR: next_pend.pkt = w_byte;
               MARK_ADDR: next_pend.marker = w_byte;
               RETRY_ADDR: next_pend.retry = w_byte;
               BEACON_ADDR: next_pend.beacon = w_byte;
               GAP_ADDR: next_pend.gap = w_byte;
               GUARD_ADDR: next_pend.guard = w_byte;
               CTO_ADDR: next_pend.cto = w_byte;
               CTRL_ADDR: next_apply = w_byte[CTRL_APPLY_BIT];
               STATUS_ADDR: clr = w_byte[IRQ_W-1:0];
               MASK_ADDR: next_mask = w_byte[IRQ_W-1:0];
               default: ;
            endcase
         end
      end
      if (arvalid && arready) begin
         next_rvalid = 1'b1;
         next_rresp = mapped(araddr) ? RESP_OKAY : RESP_SLVERR;
         next_rdata = '0;
         case (araddr)
            FREQ_ADDR: next_rdata[7:0] = pend.freq;
            PKT_ADDR: next_rdata[7:0] = pend.pkt;
            RSVA_ADDR: next_rdata[7:0] = RSVA_RST;
            RSVB_ADDR: next_rdata[7:0] = RSVB_RST;
            MARK_ADDR: next_rdata[7:0] = pend.marker;
            RETRY_ADDR: next_rdata[7:0] = pend.retry;
            BEACON_ADDR: next_rdata[7:0] = pend.beacon;
            RSVC_ADDR: next_rdata[7:0] = RSVC_RST;
            GAP_ADDR: next_rdata[7:0] = pend.gap;
            GUARD_ADDR: next_rdata[7:0] = pend.guard;
            CTO_ADDR: next_rdata[7:0] = pend.cto;
            RSVD_ADDR: next_rdata[7:0] = RSVD_RST;
            STATUS_ADDR: next_rdata[IRQ_W-1:0] = status;
            MASK_ADDR: next_rdata[IRQ_W-1:0] = mask;
            STATE_ADDR: next_rdata[23:0] = {rcnt, idle, 6'h0,
               (mode == MSC_CMD_WAIT), busy};
            default: ;
         endcase
      end
      // RULE17 settings copied only on reset
      next_act = apply ? pend : act;
   end

   // bus register stage
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         aw_got <= 1'b0;
         aw_addr <= '0;
         w_got <= 1'b0;
         w_byte <= '0;
         w_lane <= 1'b0;
         bvalid <= 1'b0;
         bresp <= RESP_OKAY;
         rvalid <= 1'b0;
         rresp <= RESP_OKAY;
         rdata <= '0;
         pend <= CFG_RST;
         act <= CFG_RST;
         mask <= '0;
         apply <= 1'b0;
      end else if (ce) begin
         aw_got <= next_aw_got;
         aw_addr <= next_aw_addr;
         w_got <= next_w_got;
         w_byte <= next_w_byte;
         w_lane <= next_w_lane;
         bvalid <= next_bvalid;
         bresp <= next_bresp;
         rvalid <= next_rvalid;
         rresp <= next_rresp;
         rdata <= next_rdata;
         pend <= next_pend;
         act <= next_act;
         mask <= next_mask;
         apply <= next_apply;
      end
   end

   // RULE13 guard in tenths; RULE14 zero and 255 special
   assign guard_ok = (act.guard == GUARD_ANY) ||
      (act.guard != GUARD_NEVER && idle >= act.guard);
   // RULE16 timeout in tenths, zero disables it
   assign tmo = (act.cto != CTO_OFF) && (idle >= act.cto) && !rx_valid;
   // RULE6 marker compare
   assign hdr = rx_valid && (rx_data == act.marker);
   // RULE3 multidrop spacing; RULE11 character gap
   assign need = (multidrop_en && out_first) ? act.pkt : act.gap;
   assign gap_ok = !busy && (gap_cnt >= need);
   // RULE12 drain while gap allows, no other spacing
   assign out_ready = gap_ok;
   // RULE9 broadcast gets one extra attempt
   assign limit = {1'b0, act.retry} + {8'h0, tx_broadcast};
   assign irq = |(status & mask);

   // interpreter, pacing, retry and roaming: next values
   always_comb begin
      next_mode = mode;
      next_fwd_valid = 1'b0;
      next_fwd_data = fwd_data;
      next_cmd_valid = 1'b0;
      next_cmd_data = cmd_data;
      next_gap_cnt = gap_cnt;
      next_busy = busy;
      next_term_valid = term_valid && !term_ready;
      next_term_data = term_data;
      next_rcnt = rcnt;
      next_retry_req = 1'b0;
      next_retry_error = 1'b0;
      next_scan = 1'b0;
      ev = '0;
      next_idle = idle;
      // RULE19 idle count restarts per character
      if (rx_valid) begin
         next_idle = '0;
      end else if (tenth_tick && idle != CNT_MAX) begin
         next_idle = idle + 1'b1;
      end
      case (mode)
         MSC_DATA_WAIT: begin
            // RULE7 marker after idle guard opens a command
            if (hdr && guard_ok) begin
               next_mode = MSC_CMD_WAIT;
               ev[IRQ_CMD] = 1'b1;
            end else if (rx_valid) begin
               // RULE18 early marker goes out as data
               next_fwd_valid = 1'b1;
               next_fwd_data = rx_data;
            end
         end
         MSC_CMD_WAIT: begin
            if (rx_valid) begin
               next_cmd_valid = 1'b1;
               next_cmd_data = rx_data;
            end
            if (cmd_end) begin
               next_mode = MSC_DATA_WAIT;
            end else if (tmo) begin
               // RULE15 timeout back to data wait
               next_mode = MSC_DATA_WAIT;
               ev[IRQ_TMO] = 1'b1;
            end
         end
         default: next_mode = MSC_DATA_WAIT;
      endcase
      // RULE11 gap measured from stop bit
      if (term_done) begin
         next_gap_cnt = '0;
         next_busy = 1'b0;
      end else if (ms_tick && gap_cnt != CNT_MAX) begin
         next_gap_cnt = gap_cnt + 1'b1;
      end
      if (out_valid && gap_ok) begin
         next_busy = 1'b1;
         next_term_valid = 1'b1;
         next_term_data = out_data;
      end
      // RULE8 attempts bounded by count
      if (tx_fail) begin
         if ({1'b0, rcnt} < limit) begin
            next_rcnt = rcnt + 1'b1;
            next_retry_req = 1'b1;
         end else begin
            // RULE9 limit exceeded, report error
            next_rcnt = '0;
            next_retry_error = 1'b1;
            ev[IRQ_ERR] = 1'b1;
         end
      end else if (tx_ok) begin
         next_rcnt = '0;
      end
      // RULE10 beacon weaker than minus threshold
      if (roam_en && beacon_valid && beacon_level > act.beacon) begin
         next_scan = 1'b1;
         ev[IRQ_SCAN] = 1'b1;
      end
      // set wins over clear in one cycle
      next_status = (status & ~clr) | ev;
      // RULE1 grouping split; RULE2 group number
      next_per = msc_per_group(act.freq[GRP_MSB:GRP_LSB]);
      next_total = msc_groups(act.freq[GRP_MSB:GRP_LSB]);
      next_num = act.freq[NUM_MSB:0];
      next_legal = next_num < next_total;
   end

   // core register stage
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         mode <= MSC_DATA_WAIT;
         idle <= IDLE_RST;
         fwd_valid <= 1'b0;
         fwd_data <= '0;
         cmd_valid <= 1'b0;
         cmd_data <= '0;
         gap_cnt <= IDLE_RST;
         busy <= 1'b0;
         term_valid <= 1'b0;
         term_data <= '0;
         rcnt <= '0;
         retry_req <= 1'b0;
         retry_error <= 1'b0;
         scan_start <= 1'b0;
         status <= '0;
         freq_per_group <= '0;
         group_total <= '0;
         group_num <= '0;
         group_legal <= 1'b0;
      end else if (ce) begin
         mode <= next_mode;
         idle <= next_idle;
         fwd_valid <= next_fwd_valid;
         fwd_data <= next_fwd_data;
         cmd_valid <= next_cmd_valid;
         cmd_data <= next_cmd_data;
         gap_cnt <= next_gap_cnt;
         busy <= next_busy;
         term_valid <= next_term_valid;
         term_data <= next_term_data;
         rcnt <= next_rcnt;
         retry_req <= next_retry_req;
         retry_error <= next_retry_error;
         scan_start <= next_scan;
         status <= next_status;
         freq_per_group <= next_per;
         group_total <= next_total;
         group_num <= next_num;
         group_legal <= next_legal;
      end
   end

   // checks
   default clocking cb @(posedge aclk); endclocking
   default disable iff (!aresetn);

   grp_split_a: assert property (ce && aresetn |=> //RULE1
      32'(freq_per_group) * 32'(group_total) == 24) else $error("bad grouping");
   grp_legal_a: assert property (ce |=> group_legal == //RULE2
      (group_num < group_total)) else $error("group legality");
   hdr_enter_a: assert property (ce && mode == MSC_DATA_WAIT && hdr //RULE7
      && guard_ok |=> mode == MSC_CMD_WAIT && !fwd_valid)
      else $error("marker ignored");
   early_fwd_a: assert property (ce && mode == MSC_DATA_WAIT && //RULE18
      rx_valid && !guard_ok |=> fwd_valid && fwd_data == $past(rx_data))
      else $error("marker not forwarded");
   never_cmd_a: assert property (ce && act.guard == GUARD_NEVER && //RULE14
      mode == MSC_DATA_WAIT && !apply |=> mode == MSC_DATA_WAIT)
      else $error("command opened");
   cto_off_a: assert property (ce && mode == MSC_CMD_WAIT && //RULE16
      act.cto == CTO_OFF && !cmd_end |=> mode == MSC_CMD_WAIT)
      else $error("timeout while off");
   retry_err_a: assert property (ce && tx_fail && //RULE9
      {1'b0, rcnt} >= limit |=> retry_error && !retry_req && rcnt == 0)
      else $error("no error at limit");
   retry_cap_a: assert property (rcnt <= {1'b0, act.retry} + 9'h1) //RULE8
      else $error("retry count high");
   gap_hold_a: assert property (ce && term_done && act.gap != 8'h0 //RULE11
      && !multidrop_en |=> !out_ready) else $error("gap not held");
   pkt_gap_a: assert property (out_valid && out_ready && multidrop_en //RULE3
      && out_first |-> gap_cnt >= act.pkt) else $error("packet gap short");
   scan_a: assert property (ce && roam_en && beacon_valid && //RULE10
      beacon_level > act.beacon |=> scan_start) else $error("no scan");
   hold_cfg_a: assert property (ce && !apply |=> $stable(act)) //RULE17
      else $error("settings changed early");

   cmd_seen_c: cover property (mode == MSC_DATA_WAIT ##1
      mode == MSC_CMD_WAIT);
   tmo_seen_c: cover property (ce && mode == MSC_CMD_WAIT && tmo);
   err_seen_c: cover property (retry_error);
   scan_seen_c: cover property (scan_start && irq);
endmodule : msc_core

/* File: verif/msc_term_model.sv */
// transmitter model on the terminal side of msc_core
// assumes term_valid is held until term_ready
`timescale 1ns/1ps
module msc_term_model (
   // clock and reset
   input wire logic aclk,
   input wire logic aresetn,
   // character handshake
   input wire logic term_valid,
   output logic term_ready,
   output logic term_done
);
   int cnt; // frame cycles left
   // one char per frame; ready only while idle
   always @(posedge aclk) begin
      term_done <= 1'h0;
      term_ready <= 1'h0;
      if (!aresetn) begin
         cnt <= 0;
      end else if (term_ready && term_valid) begin
         cnt <= 3;
      end else if (cnt > 0) begin
         cnt <= cnt - 1;
         term_done <= (cnt == 1);
      end else begin
         term_ready <= 1'h1;
      end
   end
endmodule : msc_term_model

/* File: verif/modem_serial_command_params_tb_top.sv */
// self-checking bench for msc_core, ms = 4 and tenth = 40 cycles
// assumes msc_term_model acts as the transmitter
`timescale 1ns/1ps
module modem_serial_command_params_tb_top import msc_pkg::*; ;
   logic aclk = 1'h0, aresetn = 1'h0, ce = 1'h1, bready = 1'h1;
   logic rready = 1'h1, awvalid = 1'h0, wvalid = 1'h0, arvalid = 1'h0;
   logic rx_valid = 1'h0, cmd_end = 1'h0, out_valid = 1'h0;
   logic out_first = 1'h0, multidrop_en = 1'h0, tx_fail = 1'h0;
   logic tx_ok = 1'h0, tx_broadcast = 1'h0, roam_en = 1'h0;
   logic beacon_valid = 1'h0, term_ready, term_done, qi;
   logic [11:0] awaddr = 12'h0, araddr = 12'h0;
   logic [31:0] wdata = 32'h0, rdata, d;
   logic [3:0] wstrb = 4'hf;
   logic [7:0] rx_data = 8'h0, out_data = 8'h0, beacon_level = 8'h0;
   logic awready, wready, bvalid, arready, rvalid, fwd_valid, cmd_valid;
   logic out_ready, term_valid, retry_req, retry_error, scan_start;
   logic group_legal, irq;
   logic [1:0] bresp, rresp, r;
   logic [7:0] fwd_data, cmd_data, term_data;
   logic [4:0] freq_per_group, group_total, group_num;
   logic [8:0] fv, cv;
   logic [2:0] q;
   int errors = 0, total_checks = 0;
   msc_core #(.MS_TICKS(4), .TENTH_TICKS(40)) dut_u (.*);
   msc_term_model term_u (.*);
   always #2.5 aclk = ~aclk;
   task automatic chk(input string n, input logic [31:0] g, e);
      total_checks++;
      if (g !== e) begin
         errors++;
         $display("CHECK FAILED %s exp %h got %h", n, e, g);
      end
   endtask : chk
   task automatic close_out;
      $display("errors %0d checks %0d", errors, total_checks);
      if (errors == 0 && total_checks > 0) begin
         $display("SIMULATION PASSED");
      end else begin
         $display("SIMULATION FAILED");
      end
      $finish;
   endtask : close_out
   task automatic wr(input logic [11:0] a, input logic [7:0] v);
      logic ta, tw, tb;
      awaddr <= a;
      wdata <= {24'h0, v};
      awvalid <= 1'h1;
      wvalid <= 1'h1;
      do begin
         @(negedge aclk);
         ta = awready;
         tw = wready;
         tb = bvalid;
         r = bresp;
         @(posedge aclk);
         if (ta) awvalid <= 1'h0;
         if (tw) wvalid <= 1'h0;
      end while (!tb);
   endtask : wr
   task automatic rd(input logic [11:0] a);
      logic ta, tv;
      araddr <= a;
      arvalid <= 1'h1;
      do begin
         @(negedge aclk);
         ta = arready;
         tv = rvalid;
         d = rdata;
         r = rresp;
         qi = irq;
         @(posedge aclk);
         if (ta) arvalid <= 1'h0;
      end while (!tv);
   endtask : rd
   task automatic apply;
      wr(CTRL_ADDR, 8'h01);
      repeat (3) @(posedge aclk);
   endtask : apply
   // one-cycle event: 0 char, 1 radio failure, 2 beacon
   task automatic ev(input int k, input logic [7:0] c);
      rx_valid <= (k == 0);
      tx_fail <= (k == 1);
      beacon_valid <= (k == 2);
      rx_data <= c;
      beacon_level <= c;
      @(posedge aclk);
      {rx_valid, tx_fail, beacon_valid} <= 3'h0;
      @(negedge aclk);
      fv = {fwd_valid, fwd_data};
      cv = {cmd_valid, cmd_data};
      q = {retry_req, retry_error, scan_start};
      @(posedge aclk);
   endtask : ev
   task automatic s_regs;
      logic [95:0] rv = 96'ha0_05_11_13_40_32_b4_1e_00_00_32_32;
      for (int i = 0; i < 12; i++) begin
         rd(FREQ_ADDR + 12'(4 * i));
         chk("reset value", d, {24'h0, rv[95 - 8 * i -: 8]});
      end
      rd(12'h100);
      chk("unmapped", r, RESP_SLVERR);
   endtask : s_regs
   task automatic s_freq;
      logic [63:0] pg = 64'h18_0c_08_06_04_03_02_01;
      logic [4:0] e;
      for (int m = 0; m < 8; m++) begin
         e = 5'(24 / pg[63 - 8 * m -: 8]);
         wr(FREQ_ADDR, {3'(m), 5'h01});
         apply;
         @(negedge aclk);
         chk("per group", freq_per_group, pg[63 - 8 * m -: 8]);
         chk("groups", group_total, e);
         chk("group", {group_num, group_legal}, {5'h01, e > 5'h01});
         @(posedge aclk);
      end
   endtask : s_freq
   task automatic s_cmd;
      ev(0, 8'h40);
      chk("marker", fv[8], 1'h0);
      ev(0, 8'h31);
      chk("cmd char", cv, 9'h131);
      rd(STATUS_ADDR);
      chk("masked", {d[0], qi}, 2'h2);
      wr(MASK_ADDR, 8'h01);
      rd(STATUS_ADDR);
      chk("irq", qi, 1'h1);
      wr(STATUS_ADDR, 8'h01);
      rd(STATUS_ADDR);
      chk("cleared", {d[0], qi}, 2'h0);
      cmd_end <= 1'h1;
      @(posedge aclk);
      cmd_end <= 1'h0;
      ev(0, 8'h41);
      chk("data", fv, 9'h141);
   endtask : s_cmd
   task automatic s_guard;
      wr(MARK_ADDR, 8'h23);
      ev(0, 8'h23);
      chk("not applied", fv, 9'h123);
      wr(GUARD_ADDR, 8'h01);
      wr(CTO_ADDR, 8'h01);
      apply;
      ev(0, 8'h41);
      ev(0, 8'h23);
      chk("early marker", fv, 9'h123);
      repeat (50) @(posedge aclk);
      ev(0, 8'h23);
      chk("late marker", fv[8], 1'h0);
      repeat (50) @(posedge aclk);
      ev(0, 8'h41);
      chk("timed out", fv, 9'h141);
   endtask : s_guard
   task automatic s_retry;
      wr(RETRY_ADDR, 8'h01);
      apply;
      for (int b = 0; b < 2; b++) begin
         tx_broadcast <= b[0];
         for (int k = 0; k <= 1 + b; k++) begin
            ev(1, 8'h0);
            chk("retry", q[2:1], (k < 1 + b) ? 2'h2 : 2'h1);
         end
      end
   endtask : s_retry
   task automatic s_roam;
      ev(2, 8'hb5);
      chk("roam off", q[0], 1'h0);
      roam_en <= 1'h1;
      ev(2, 8'hb5);
      chk("weak", q[0], 1'h1);
      ev(2, 8'hb4);
      chk("at limit", q[0], 1'h0);
   endtask : s_roam
   task automatic s_gap;
      int n;
      wr(GAP_ADDR, 8'h02);
      apply;
      for (int m = 0; m < 2; m++) begin
         multidrop_en <= m[0];
         out_first <= m[0];
         out_data <= 8'h55;
         out_valid <= 1'h1;
         do @(negedge aclk); while (!out_ready);
         @(posedge aclk);
         out_valid <= 1'h0;
         n = 0;
         do @(negedge aclk); while (!term_done);
         chk("term data", term_data, 8'h55);
         do begin
            @(negedge aclk);
            n++;
         end while (!out_ready);
         chk("gap", n inside {[8 + 12 * m : 10 + 12 * m]}, 1'h1);
         @(posedge aclk);
      end
   endtask : s_gap
   initial begin
      repeat (4) @(posedge aclk);
      aresetn <= 1'h1;
      s_regs;
      s_freq;
      s_cmd;
      s_guard;
      s_retry;
      s_roam;
      s_gap;
      close_out;
   end
   // watchdog
   initial begin
      repeat (20000) @(posedge aclk);
      errors++;
      close_out;
   end
endmodule : modem_serial_command_params_tb_top
